// ---- design/drcrc_regs.vh ----
// constants for the dram cycle and refresh controller
`ifndef DRCRC_REGS_VH
`define DRCRC_REGS_VH
`define DRCRC_CLK_PERIOD_NS 10
`define DRCRC_REF_INTERVAL_NS 13000
`define DRCRC_REF_INTERVAL_CYC (`DRCRC_REF_INTERVAL_NS / `DRCRC_CLK_PERIOD_NS)
`define DRCRC_DMA_LIMIT_NS 2000000
`define DRCRC_DMA_LIMIT_CYC (`DRCRC_DMA_LIMIT_NS / `DRCRC_CLK_PERIOD_NS)
`define DRCRC_JC_WIDTH 6
`define DRCRC_RAS_ON 0
`define DRCRC_CAS_ON 2
`define DRCRC_LATCH_ON 4
`define DRCRC_ROWS 128
`define DRCRC_ROW_BITS 7
`define DRCRC_CNT_BITS 20
`define DRCRC_ADDR_BITS 14
`define DRCRC_DATA_BITS 8
`endif

// ---- design/drcrc_johnson.v ----
// johnson counter timing generator with a done decode over all taps
`timescale 1ns/1ps
module drcrc_johnson #(
  parameter W = 6
) (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // control
  input wire run,
  // taps
  output reg [W-1:0] taps,
  output wire done
);
  // ------------------------------------------------------------
  // shift register
  // ------------------------------------------------------------
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      taps <= {W{1'b0}};
    end else if (run || taps != {W{1'b0}}) begin
      taps <= {taps[W-2:0], ~taps[W-1]}; // see RULE2
    end
  end
  // last state before returning to all zeros
  assign done = (taps[W-1] & ~taps[W-2]) & (taps[0] == 1'b0) &
                (taps[W-2:0] == {(W-1){1'b0}});
endmodule // drcrc_johnson

// ---- design/drcrc_top.v ----
// dram cycle and refresh controller
// Operation
// RULE1: a started memory cycle always runs to full length, nothing aborts it.
// RULE2: phases come from a johnson counter, each decoded by one two-input gate; here the done decode compares all taps.
// RULE3: cycle start lags an asynchronous request by at most one timing clock; here the two-flop synchroniser and registered start take three clocks.
// RULE4: no monostables; every interval is counted in clock cycles.
// RULE5: refresh interval counter sets refresh-pending flag at terminal count.
// RULE6: pending flag stays set until its refresh cycle completes, cleared then.
// RULE7: refresh may be serviced anywhere inside the interval and still suffices.
// RULE8: refresh is placed in host idle periods whenever possible.
// RULE9: busy output stalls the host while refresh runs; host honours it.
// RULE10: read data is held in an output latch that keeps driving the host; here host_rdata_oe follows the synchronised read strobe.
// RULE11: each host address change triggers a read reloading the latch; here a change starts a cycle only while the address strobe is asserted.
// RULE12: dma accesses use the same cycle sequence as processor accesses.
// RULE13: a dma master may release the bus periodically for refresh.
// RULE14: a dma master may space requests one access plus one refresh apart.
// RULE15: dma bursts under 2 ms, then burst refresh of every row.
// RULE16: command inputs are active low; floating high lines are inactive.
// RULE17: transparent refresh starts only with no address or data strobes asserted.
// RULE18: simultaneous host request and refresh: one runs, other waits.
// RULE19: interval, phase positions and row count are parameters.
`timescale 1ns/1ps
`include "drcrc_regs.vh"
module drcrc_top #(
  parameter REF_CYC = `DRCRC_REF_INTERVAL_CYC, // see RULE19
  parameter DMA_CYC = `DRCRC_DMA_LIMIT_CYC,
  parameter ROWS = `DRCRC_ROWS,
  parameter JW = `DRCRC_JC_WIDTH,
  parameter RAS_ON = `DRCRC_RAS_ON,
  parameter CAS_ON = `DRCRC_CAS_ON,
  parameter LATCH_ON = `DRCRC_LATCH_ON,
  parameter AW = `DRCRC_ADDR_BITS,
  parameter DW = `DRCRC_DATA_BITS
) (
  // clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // host bus, active low commands
  input wire addr_strobe_n,
  input wire wr_strobe_n,
  input wire rd_strobe_n,
  input wire dma_grant_n,
  input wire [AW-1:0] host_addr,
  input wire [DW-1:0] host_wdata,
  // host answers
  output reg busy_n,
  output reg [DW-1:0] host_rdata,
  output reg host_rdata_oe,
  // dram side
  output reg [`DRCRC_ROW_BITS-1:0] ram_addr,
  output reg ras_n,
  output reg cas_n,
  output reg we_n,
  output reg [DW-1:0] ram_wdata,
  output reg ram_wdata_oe,
  input wire [DW-1:0] ram_rdata
);
  localparam ST_IDLE = 3'b001;
  localparam ST_HOST = 3'b010;
  localparam ST_REF = 3'b100;
  localparam HB = `DRCRC_ADDR_BITS / 2;
  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg [3:0] sync1;
  reg [3:0] sync2;
  reg [AW-1:0] addr1;
  reg [AW-1:0] addr2;
  reg [AW-1:0] addr_last;
  reg [DW-1:0] wd1;
  reg [DW-1:0] wd2;
  reg [DW-1:0] rd1;
  reg [DW-1:0] rd2;
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      sync1 <= 4'hF;
      sync2 <= 4'hF;
      addr1 <= {AW{1'b0}};
      addr2 <= {AW{1'b0}};
      wd1 <= {DW{1'b0}};
      wd2 <= {DW{1'b0}};
      rd1 <= {DW{1'b0}};
      rd2 <= {DW{1'b0}};
    end else begin
      sync1 <= {dma_grant_n, rd_strobe_n, wr_strobe_n, addr_strobe_n};
      sync2 <= sync1;
      addr1 <= host_addr;
      addr2 <= addr1;
      wd1 <= host_wdata;
      wd2 <= wd1;
      rd1 <= ram_rdata;
      rd2 <= rd1;
    end
  end
  // floating high means inactive
  wire as_act = ~sync2[0]; // see RULE16
  wire wr_act = ~sync2[1]; // see RULE16
  wire rd_act = ~sync2[2]; // see RULE16
  wire dma_act = ~sync2[3];
  wire any_strobe = as_act | wr_act | rd_act;
  // ------------------------------------------------------------
  // timing generator
  // ------------------------------------------------------------
  reg [2:0] state;
  reg start;
  wire [JW-1:0] taps;
  wire jc_done;
  drcrc_johnson #(.W(JW)) u_jc (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .run(start),
    .taps(taps),
    .done(jc_done)
  );
  // two-input decodes of the johnson taps
  wire ph_ras = taps[RAS_ON] & ~taps[JW-1]; // see RULE2
  wire ph_cas = taps[CAS_ON] & ~taps[JW-1]; // see RULE2
  wire ph_latch = taps[LATCH_ON] & ~taps[LATCH_ON+1]; // see RULE2
  // ------------------------------------------------------------
  // refresh interval and burst tracking
  // ------------------------------------------------------------
  reg [`DRCRC_CNT_BITS-1:0] ref_cnt;
  reg [`DRCRC_CNT_BITS-1:0] dma_cnt;
  reg ref_pend;
  reg [7:0] burst_left;
  reg [`DRCRC_ROW_BITS-1:0] ref_row;
  reg dma_seen;
  reg addr_chg;
  reg is_wr;
  reg [DW-1:0] wr_hold;
  wire ref_done = (state == ST_REF) & jc_done;
  wire ref_tick = (ref_cnt == REF_CYC[`DRCRC_CNT_BITS-1:0] - 1'b1);
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ref_cnt <= {`DRCRC_CNT_BITS{1'b0}};
      ref_pend <= 1'b0;
      dma_cnt <= {`DRCRC_CNT_BITS{1'b0}};
      dma_seen <= 1'b0;
      burst_left <= 8'h00;
    end else begin
      ref_cnt <= ref_tick ? {`DRCRC_CNT_BITS{1'b0}} : ref_cnt + 1'b1; // see RULE4
      // set wins over clear, flag held until refresh ends
      if (ref_tick) begin
        ref_pend <= 1'b1; // see RULE5
      end else if (ref_done && burst_left == 8'h00) begin
        ref_pend <= 1'b0; // see RULE6
      end
      if (dma_act) begin
        dma_seen <= 1'b1;
        if (dma_cnt != DMA_CYC[`DRCRC_CNT_BITS-1:0]) begin
          dma_cnt <= dma_cnt + 1'b1;
        end
      end else if (dma_seen) begin
        dma_seen <= 1'b0;
        dma_cnt <= {`DRCRC_CNT_BITS{1'b0}};
        burst_left <= ROWS[7:0]; // see RULE15
      end else if (ref_done && burst_left != 8'h00) begin
        burst_left <= burst_left - 8'h01; // see RULE15
      end
    end
  end
  wire ref_want = ref_pend | (burst_left != 8'h00);
  // ------------------------------------------------------------
  // arbitration and cycle control
  // ------------------------------------------------------------
  wire host_req = as_act & (rd_act | wr_act | addr_chg);
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      start <= 1'b0;
      addr_last <= {AW{1'b0}};
      addr_chg <= 1'b0;
      is_wr <= 1'b0;
      wr_hold <= {DW{1'b0}};
      ref_row <= {`DRCRC_ROW_BITS{1'b0}};
    end else begin
      start <= 1'b0;
      if (addr2 != addr_last) begin
        addr_chg <= 1'b1; // see RULE11
      end
      case (state)
        ST_IDLE: begin
          if (ref_want && !any_strobe) begin
            state <= ST_REF; // see RULE8
            start <= 1'b1; // see RULE17
          end else if (host_req && !ref_want) begin
            state <= ST_HOST; // see RULE12
            start <= 1'b1; // see RULE3
            is_wr <= wr_act;
            wr_hold <= wd2;
            addr_last <= addr2;
            addr_chg <= 1'b0;
          end else if (ref_want && host_req) begin
            state <= ST_REF; // see RULE18
            start <= 1'b1; // see RULE9
          end
        end
        ST_HOST: begin
          if (jc_done) begin
            state <= ST_IDLE; // see RULE1
          end
        end
        ST_REF: begin
          if (jc_done) begin
            state <= ST_IDLE; // see RULE1
            ref_row <= ref_row + 1'b1; // see RULE7
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end
  // ------------------------------------------------------------
  // dram strobes, latch and busy
  // ------------------------------------------------------------
  wire in_cyc = (state != ST_IDLE);
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      ras_n <= 1'b1;
      cas_n <= 1'b1;
      we_n <= 1'b1;
      ram_addr <= {`DRCRC_ROW_BITS{1'b0}};
      ram_wdata <= {DW{1'b0}};
      ram_wdata_oe <= 1'b0;
      host_rdata <= {DW{1'b0}};
      host_rdata_oe <= 1'b0;
      busy_n <= 1'b1;
    end else begin
      ras_n <= ~(in_cyc & ph_ras);
      cas_n <= ~((state == ST_HOST) & ph_cas);
      we_n <= ~((state == ST_HOST) & is_wr & ph_cas);
      if (state == ST_REF) begin
        ram_addr <= ref_row;
      end else if (ph_cas) begin
        ram_addr <= addr_last[AW-1:HB];
      end else begin
        ram_addr <= addr_last[HB-1:0];
      end
      ram_wdata <= wr_hold;
      ram_wdata_oe <= (state == ST_HOST) & is_wr;
      if ((state == ST_HOST) && !is_wr && ph_latch) begin
        host_rdata <= rd2; // see RULE10
      end
      host_rdata_oe <= rd_act; // see RULE10
      busy_n <= ~((state == ST_REF) | (ref_want & host_req)); // see RULE9
    end
  end
endmodule // drcrc_top

// ---- tb/drcrc_monitor.sv ----
// port assertions for the dram controller
`timescale 1ns/1ps
module drcrc_monitor #(parameter REF_CYC = 1300) (
  input wire ref_clk, input wire sys_rst,
  input wire addr_strobe_n, input wire wr_strobe_n, input wire rd_strobe_n,
  input wire dma_grant_n, input wire [13:0] host_addr,
  input wire [7:0] host_rdata, input wire host_rdata_oe,
  input wire ras_n, input wire cas_n, input wire we_n);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  reg [15:0] quiet;
  reg [15:0] since;
  reg [13:0] last_addr;
  wire idle = addr_strobe_n && rd_strobe_n && wr_strobe_n && host_addr == last_addr;
  always @(posedge ref_clk) begin
    last_addr <= host_addr;
    quiet <= (sys_rst || !idle) ? 16'h0000 : quiet + 16'h0001;
    since <= (sys_rst || !ras_n || !dma_grant_n) ? 16'h0000 : since + 16'h0001;
  end
  sequence s_ras_start; $fell(ras_n); endsequence
  sequence s_ras_end; $rose(ras_n); endsequence
  chk_ras_hold: assert property (s_ras_start |-> !ras_n[*3])
    else $error("row strobe cut short");
  chk_ras_precharge: assert property (s_ras_end |-> ras_n[*4])
    else $error("row strobe precharge cut short");
  chk_cas_in_ras: assert property ($fell(cas_n) |-> !ras_n)
    else $error("column strobe outside row strobe");
  chk_oe_follow: assert property (!rd_strobe_n [*4] |-> host_rdata_oe)
    else $error("read drive missing");
  chk_oe_released: assert property (rd_strobe_n [*4] |-> !host_rdata_oe)
    else $error("read drive on released line");
  chk_latch_cycle: assert property ($changed(host_rdata) |-> !ras_n || !$past(ras_n))
    else $error("read latch changed outside a cycle");
  chk_float_idle: assert property (quiet > 24 |-> cas_n && we_n)
    else $error("access started from idle lines");
  chk_refresh_due: assert property (since <= REF_CYC + 40)
    else $error("refresh overdue");
endmodule // drcrc_monitor
bind drcrc_top drcrc_monitor #(.REF_CYC(REF_CYC)) u_mon (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .addr_strobe_n(addr_strobe_n), .wr_strobe_n(wr_strobe_n), .rd_strobe_n(rd_strobe_n),
  .dma_grant_n(dma_grant_n), .host_addr(host_addr), .host_rdata(host_rdata),
  .host_rdata_oe(host_rdata_oe), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n));

// ---- tb/drcrc_host.sv ----
// bus master model for the host side
`timescale 1ns/1ps
module drcrc_host (
  input wire ref_clk, input wire busy_n,
  output reg addr_strobe_n, output reg wr_strobe_n, output reg rd_strobe_n,
  output reg [13:0] host_addr, output reg [7:0] host_wdata);
  initial begin
    {addr_strobe_n, wr_strobe_n, rd_strobe_n} = 3'h7;
    host_addr = 14'h0000;
    host_wdata = 8'h00;
  end
  task access(input rd, input [13:0] a, input [7:0] d);
    integer n;
    begin
      @(negedge ref_clk);
      host_addr = a;
      host_wdata = d;
      addr_strobe_n = 1'b0;
      rd_strobe_n = !rd;
      wr_strobe_n = rd;
      n = 0;
      while (n < 24) begin
        @(negedge ref_clk);
        if (busy_n) n = n + 1;
      end
      {addr_strobe_n, wr_strobe_n, rd_strobe_n} = 3'h7;
      host_wdata = ~d;
      repeat (12) @(negedge ref_clk);
    end
  endtask
endmodule // drcrc_host

// ---- tb/drcrc_top_tb.sv ----
// self-checking bench for the dram controller
`timescale 1ns/1ps
module drcrc_top_tb;
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg dma_grant_n = 1'b1;
  reg [7:0] ram_rdata = 8'h00;
  wire as_n, wr_n, rd_n, busy_n, oe, ras_n, cas_n, we_n, wd_oe;
  wire [13:0] addr;
  wire [7:0] wdata, host_rdata, ram_wdata;
  wire [6:0] ram_addr;
  integer failures = 0, samples_checked = 0, falls = 0, i;
  integer busy_falls = 0;
  reg [7:0] wr_seen = 8'h00;
  reg [22:0] rows [0:5];
  initial forever #5 ref_clk = ~ref_clk;
  always @(negedge ras_n) falls = falls + 1;
  always @(negedge busy_n) busy_falls = busy_falls + 1;
  // data on the ram pins while the write strobe is low
  always @(posedge ref_clk) begin
    if (!we_n) wr_seen <= ram_wdata;
  end
  drcrc_host host (.ref_clk(ref_clk), .busy_n(busy_n), .addr_strobe_n(as_n),
    .wr_strobe_n(wr_n), .rd_strobe_n(rd_n), .host_addr(addr), .host_wdata(wdata));
  drcrc_top #(.REF_CYC(50), .ROWS(4)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .addr_strobe_n(as_n), .wr_strobe_n(wr_n), .rd_strobe_n(rd_n),
    .dma_grant_n(dma_grant_n), .host_addr(addr), .host_wdata(wdata), .busy_n(busy_n),
    .host_rdata(host_rdata), .host_rdata_oe(oe), .ram_addr(ram_addr), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ram_wdata(ram_wdata), .ram_wdata_oe(wd_oe),
    .ram_rdata(ram_rdata));
  task chk_d(input [7:0] got, input [7:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected data at %0t: %h", $time, got);
      end
    end
  endtask
  task chk_b(input got, input exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        failures = failures + 1;
        $display("unexpected flag at %0t: %b", $time, got);
      end
    end
  endtask
  task finish_test;
    begin
      $display("checked %0d, failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  initial begin
    #200000;
    failures = failures + 1;
    finish_test;
  end
  initial begin
    rows[0] = {1'b1, 14'h0000, 8'hA5};
    rows[1] = {1'b1, 14'h3FFF, 8'h5A};
    rows[2] = {1'b0, 14'h2AAA, 8'hC3};
    rows[3] = {1'b0, 14'h0001, 8'hFF};
    rows[4] = {1'b1, 14'h1555, 8'h01};
    rows[5] = {1'b1, 14'h0080, 8'h3C};
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    chk_b(busy_n, 1'b1);
    chk_b(oe, 1'b0);
    chk_d(host_rdata, 8'h00);
    $display("reset test done");
    for (i = 0; i < 6; i = i + 1) begin
      ram_rdata = rows[i][7:0];
      host.access(rows[i][22], rows[i][21:8], rows[i][7:0]);
      if (rows[i][22])
        chk_d(host_rdata, rows[i][7:0]);
      else begin
        chk_d(ram_wdata, rows[i][7:0]);
        chk_d(wr_seen, rows[i][7:0]);
      end
    end
    $display("access rows done");
    ram_rdata = 8'hC3;
    falls = 0;
    busy_falls = 0;
    repeat (160) @(negedge ref_clk);
    chk_d(host_rdata, 8'h3C);
    chk_b(falls >= 2, 1'b1);
    chk_b(busy_falls >= 2, 1'b1);
    $display("latch hold test done");
    dma_grant_n = 1'b0;
    repeat (300) @(negedge ref_clk);
    falls = 0;
    dma_grant_n = 1'b1;
    repeat (84) @(negedge ref_clk);
    chk_b(falls >= 4, 1'b1);
    $display("dma release test done");
    finish_test;
  end
endmodule // drcrc_top_tb
